// file: shared/mbd_defs.vh
`ifndef MBD_DEFS_VH
`define MBD_DEFS_VH

// ----------------------------------------------------------------------
// function codes
// ----------------------------------------------------------------------
`define MBD_FC_RD_COIL   8'h01
`define MBD_FC_RD_INPUT  8'h02
`define MBD_FC_RD_HOLD   8'h03
`define MBD_FC_RD_INREG  8'h04
`define MBD_FC_WR_COIL   8'h05
`define MBD_FC_WR_REG    8'h06
`define MBD_FC_DIAG      8'h08
`define MBD_FC_WR_COILS  8'h0f
`define MBD_FC_WR_REGS   8'h10
`define MBD_FC_SLAVE_ID  8'h11
`define MBD_FC_DEV_ID    8'h2b

// ----------------------------------------------------------------------
// exception codes
// ----------------------------------------------------------------------
`define MBD_EX_NONE      8'h00
`define MBD_EX_FUNC      8'h01
`define MBD_EX_ADDR      8'h02
`define MBD_EX_VALUE     8'h04
`define MBD_EX_BUSY      8'h06
`define MBD_EX_GATEWAY   8'h0a

// ----------------------------------------------------------------------
// addressing and frame layout
// ----------------------------------------------------------------------
`define MBD_BROADCAST    8'h00
`define MBD_BASE_MIN     8'h01
`define MBD_BASE_MAX     8'hf7
`define MBD_MAX_SECT     3'h4
`define MBD_UNITS_SECT   8'h3c
`define MBD_MAX_UNITS    8'hf0
`define MBD_FRAME_LEN    8'h08
`define MBD_MAX_WR_REGS  16'h007b
`define MBD_MAX_RD_REGS  16'h007d
`define MBD_MAX_RD_BITS  16'h07d0
`define MBD_COIL_ON      16'hff00
`define MBD_COIL_OFF     16'h0000

// ----------------------------------------------------------------------
// database regions (register locations)
// ----------------------------------------------------------------------
`define MBD_CONC_BASE    16'h0000
`define MBD_CONC_END     16'h00ff
`define MBD_FSTAT_BASE   16'h0100
`define MBD_FSTAT_END    16'h0eff
`define MBD_FCMD_BASE    16'h0f00
`define MBD_FCMD_END     16'h0f3b

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define MBD_CLK_HZ       40000000
`define MBD_FILT_TICK_MS 1
`define MBD_FILT_TICK_CYC ((`MBD_CLK_HZ / 1000) * `MBD_FILT_TICK_MS)

`endif

// file: src/mbd_dispatch.v
`timescale 1ns/1ps
`default_nettype none
`include "mbd_defs.vh"

module mbd_dispatch #(
  parameter TICK_CYCLES = `MBD_FILT_TICK_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // received frame bytes
  input  wire        rx_valid,
  input  wire [7:0]  rx_byte,
  input  wire        rx_end,
  input  wire        rx_crc_ok,
  // configuration
  input  wire [7:0]  cfg_base_addr,
  input  wire [7:0]  cfg_unit_count,
  input  wire        cfg_coil_zero,
  input  wire [15:0] cfg_filter_ms,
  input  wire        cfg_tcp,
  input  wire        gw_unavail,
  input  wire [239:0] unit_avail,
  // decoded request to reply builder
  output wire        rsp_valid,
  input  wire        rsp_ready,
  output reg  [7:0]  rsp_unit,
  output reg  [7:0]  rsp_func,
  output reg  [7:0]  rsp_exc,
  output reg  [1:0]  rsp_section,
  output reg  [15:0] rsp_reg,
  output reg  [3:0]  rsp_bit,
  output reg  [15:0] rsp_qty,
  output reg         rsp_bit_mode,
  output reg         rsp_limit_src,
  output reg         rsp_zero_bits,
  output reg         rsp_pass,
  // concentrator register write
  output reg         conc_wr,
  output reg  [15:0] conc_addr,
  output reg  [15:0] conc_data,
  // field-unit command queue
  output wire        fcmd_valid,
  input  wire        fcmd_ready,
  output reg  [7:0]  fcmd_field_unit,
  output reg  [15:0] fcmd_reg,
  output reg  [15:0] fcmd_data,
  // status
  output reg         filt_drop
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_CHECK = 3'h1;
  localparam [2:0] ST_REPLY = 3'h2;
  localparam [2:0] ST_FILT  = 3'h3;
  localparam [2:0] ST_SEND  = 3'h4;

  reg  [2:0]  state;
  reg  [7:0]  byte_cnt;
  reg  [7:0]  f_unit;
  reg  [7:0]  f_func;
  reg  [15:0] f_start;
  reg  [15:0] f_qty;
  reg         fwd_pend;
  reg  [31:0] tick_cnt;
  reg  [15:0] now_ms;
  reg  [48:0] filt_mem [0:239];
  reg  [239:0] filt_used;

  // --------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------
  // true for the two bit read codes (read coils, read inputs)
  function is_bit_code;
    input [7:0] fc;
    begin
      is_bit_code = (fc == `MBD_FC_RD_COIL) || (fc == `MBD_FC_RD_INPUT);
    end
  endfunction

  // true for the single-item write codes
  function is_wr_code;
    input [7:0] fc;
    begin
      is_wr_code = (fc == `MBD_FC_WR_COIL) || (fc == `MBD_FC_WR_REG);
    end
  endfunction

  // true when a register window lies inside [lo, hi]
  function in_span;
    input [15:0] first;
    input [16:0] last;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_span = (first >= lo) && (last <= {1'b0, hi});
    end
  endfunction

  // --------------------------------------------------------------------
  // unit address decode
  // --------------------------------------------------------------------
  // section count from configured units, 60 per logical slave
  wire [2:0]  sect_cnt  = (cfg_unit_count > 8'hb4) ? `MBD_MAX_SECT :
                          (cfg_unit_count > 8'h78) ? 3'h3 :
                          (cfg_unit_count > `MBD_UNITS_SECT) ? 3'h2 : 3'h1;
  wire [7:0]  sect_off  = f_unit - cfg_base_addr;
  wire        base_ok   = (cfg_base_addr >= `MBD_BASE_MIN) && (cfg_base_addr <= `MBD_BASE_MAX);
  // one to four addresses, section from address only
  wire        unit_mine = base_ok && (f_unit != `MBD_BROADCAST) &&
                          (f_unit >= cfg_base_addr) && ({1'b0, sect_off} < {6'h00, sect_cnt});

  // --------------------------------------------------------------------
  // address interpretation and checks
  // --------------------------------------------------------------------
  // bit codes take a bit offset
  wire        bit_mode  = is_bit_code(f_func);
  wire [15:0] reg_first = bit_mode ? {4'h0, f_start[15:4]} : f_start;
  wire [16:0] bit_last  = {1'b0, f_start} + {1'b0, f_qty} - 17'h00001;
  wire [16:0] reg_last  = is_wr_code(f_func) ? {1'b0, f_start} :
                          bit_mode ? {5'h00, bit_last[15:4]} :
                          {1'b0, f_start} + {1'b0, f_qty} - 17'h00001;
  wire        in_conc   = in_span(reg_first, reg_last, `MBD_CONC_BASE, `MBD_CONC_END);
  wire        in_fstat  = in_span(reg_first, reg_last, `MBD_FSTAT_BASE, `MBD_FSTAT_END);
  wire        in_fcmd   = in_span(reg_first, reg_last, `MBD_FCMD_BASE, `MBD_FCMD_END);
  wire [15:0] sect_units = sect_off * `MBD_UNITS_SECT;
  wire [7:0]  phys_idx  = f_start[7:0] + sect_units[7:0];
  wire        func_ok   = (f_func == `MBD_FC_RD_COIL)  || (f_func == `MBD_FC_RD_INPUT) ||
                          (f_func == `MBD_FC_RD_HOLD)  || (f_func == `MBD_FC_RD_INREG) ||
                          is_wr_code(f_func)           || (f_func == `MBD_FC_DIAG)     ||
                          (f_func == `MBD_FC_WR_COILS) || (f_func == `MBD_FC_WR_REGS)  ||
                          (f_func == `MBD_FC_SLAVE_ID) || (f_func == `MBD_FC_DEV_ID);
  wire        short_fc  = (f_func <= `MBD_FC_WR_REG);
  wire        pass_fc   = !short_fc;
  wire        fu_target = is_wr_code(f_func) && in_fcmd;

  reg  [7:0]  next_exc;

  // exception selection
  always @* begin
    next_exc = `MBD_EX_NONE;
    if (!func_ok || (short_fc && (byte_cnt != `MBD_FRAME_LEN))) begin
      next_exc = `MBD_EX_FUNC;
    end else if (cfg_tcp && gw_unavail) begin
      next_exc = `MBD_EX_GATEWAY;
    end else if ((f_func == `MBD_FC_WR_REGS) && (f_qty > `MBD_MAX_WR_REGS)) begin
      next_exc = `MBD_EX_ADDR;
    end else if (pass_fc) begin
      next_exc = `MBD_EX_NONE;
    end else if (!is_wr_code(f_func) && ((f_qty == 16'h0000) ||
                 (bit_mode && (f_qty > `MBD_MAX_RD_BITS)) ||
                 (!bit_mode && (f_qty > `MBD_MAX_RD_REGS)))) begin
      next_exc = `MBD_EX_VALUE;
    // coil value must be on or off
    end else if ((f_func == `MBD_FC_WR_COIL) &&
                 (f_qty != `MBD_COIL_ON) && (f_qty != `MBD_COIL_OFF)) begin
      next_exc = `MBD_EX_VALUE;
    end else if (f_func == `MBD_FC_RD_INPUT) begin
      next_exc = (in_fstat || in_fcmd) ? `MBD_EX_NONE : `MBD_EX_ADDR;
    end else if (!is_wr_code(f_func)) begin
      next_exc = (in_conc || in_fstat || in_fcmd) ? `MBD_EX_NONE : `MBD_EX_ADDR;
    end else if (!(in_conc || in_fcmd)) begin
      next_exc = `MBD_EX_ADDR;
    end else if (fu_target && !unit_avail[phys_idx]) begin
      next_exc = `MBD_EX_ADDR;
    // busy while a forwarded command is still waiting
    end else if (fu_target && fwd_pend) begin
      next_exc = `MBD_EX_BUSY;
    end
  end

  // --------------------------------------------------------------------
  // millisecond time base for the command filter
  // --------------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h00000000;
      now_ms   <= 16'h0000;
    end else if (tick_cnt >= TICK_CYCLES - 1) begin
      tick_cnt <= 32'h00000000;
      now_ms   <= now_ms + 16'h0001;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
    end
  end

  // duplicate check against last command to the unit
  wire [48:0] filt_ent  = filt_mem[fcmd_field_unit];
  wire [15:0] filt_age  = now_ms - filt_ent[15:0];
  wire        filt_dup  = filt_used[fcmd_field_unit] && filt_ent[48] &&
                          (filt_ent[47:16] == {fcmd_reg, fcmd_data}) && (filt_age < cfg_filter_ms);

  // filter memory update when a command leaves
  always @(posedge clk) begin
    if ((state == ST_SEND) && fcmd_ready) begin
      filt_mem[fcmd_field_unit] <= {1'b1, fcmd_reg, fcmd_data, now_ms};
    end
  end

  // --------------------------------------------------------------------
  // frame capture and dispatch sequence
  // --------------------------------------------------------------------
  assign rsp_valid  = (state == ST_REPLY);
  assign fcmd_valid = (state == ST_SEND);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state           <= ST_IDLE;
      byte_cnt        <= 8'h00;
      f_unit          <= 8'h00;
      f_func          <= 8'h00;
      f_start         <= 16'h0000;
      f_qty           <= 16'h0000;
      fwd_pend        <= 1'b0;
      filt_used       <= 240'h0;
      filt_drop       <= 1'b0;
      rsp_unit        <= 8'h00;
      rsp_func        <= 8'h00;
      rsp_exc         <= 8'h00;
      rsp_section     <= 2'h0;
      rsp_reg         <= 16'h0000;
      rsp_bit         <= 4'h0;
      rsp_qty         <= 16'h0000;
      rsp_bit_mode    <= 1'b0;
      rsp_limit_src   <= 1'b0;
      rsp_zero_bits   <= 1'b0;
      rsp_pass        <= 1'b0;
      conc_wr         <= 1'b0;
      conc_addr       <= 16'h0000;
      conc_data       <= 16'h0000;
      fcmd_field_unit <= 8'h00;
      fcmd_reg        <= 16'h0000;
      fcmd_data       <= 16'h0000;
    end else begin
      conc_wr   <= 1'b0;
      filt_drop <= 1'b0;
      case (state)
        ST_IDLE: begin
          // field order of the request frame
          if (rx_valid) begin
            case (byte_cnt)
              8'h00:   f_unit        <= rx_byte;
              8'h01:   f_func        <= rx_byte;
              8'h02:   f_start[15:8] <= rx_byte;
              8'h03:   f_start[7:0]  <= rx_byte;
              8'h04:   f_qty[15:8]   <= rx_byte;
              8'h05:   f_qty[7:0]    <= rx_byte;
              default: f_qty         <= f_qty;
            endcase
            if (byte_cnt != 8'hff) begin
              byte_cnt <= byte_cnt + 8'h01;
            end
          end
          if (rx_end) begin
            // bad crc or frame shorter than two bytes dropped silently
            if (rx_crc_ok && (byte_cnt >= 8'h02)) begin
              state <= ST_CHECK;
            end else begin
              byte_cnt <= 8'h00;
            end
          end
        end
        ST_CHECK: begin
          byte_cnt <= 8'h00;
          // each logical address answers on its own
          if (!unit_mine) begin
            state <= ST_IDLE;
          end else begin
            state         <= ST_REPLY;
            rsp_unit      <= f_unit;
            rsp_func      <= f_func;
            rsp_exc       <= next_exc;
            rsp_section   <= sect_off[1:0];
            rsp_reg       <= reg_first;
            rsp_bit       <= f_start[3:0];
            rsp_qty       <= f_qty;
            rsp_bit_mode  <= bit_mode;
            rsp_pass      <= pass_fc;
            // command coils read back limit switches
            rsp_limit_src <= (f_func == `MBD_FC_RD_COIL) && in_fcmd;
            rsp_zero_bits <= (f_func == `MBD_FC_RD_COIL) && cfg_coil_zero;
            if ((next_exc == `MBD_EX_NONE) && is_wr_code(f_func) && in_conc) begin
              conc_wr   <= 1'b1;
              conc_addr <= f_start;
              conc_data <= f_qty;
            end
            // field write held as a command
            if ((next_exc == `MBD_EX_NONE) && fu_target) begin
              fwd_pend        <= 1'b1;
              fcmd_field_unit <= phys_idx;
              fcmd_reg        <= f_start;
              fcmd_data       <= f_qty;
            end
          end
        end
        ST_REPLY: begin
          // command leaves only after reply taken
          if (rsp_ready) begin
            state <= fwd_pend ? ST_FILT : ST_IDLE;
          end
        end
        ST_FILT: begin
          if (filt_dup) begin
            filt_drop <= 1'b1;
            fwd_pend  <= 1'b0;
            state     <= ST_IDLE;
          end else begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (fcmd_ready) begin
            filt_used[fcmd_field_unit] <= 1'b1;
            fwd_pend <= 1'b0;
            state    <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: dv/mbd_dispatch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mbd_dispatch_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // frame end and configuration
  input wire logic        rx_end,
  input wire logic        rx_crc_ok,
  input wire logic [7:0]  cfg_base_addr,
  input wire logic        cfg_coil_zero,
  // reply side
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic [7:0]  rsp_unit,
  input wire logic [7:0]  rsp_func,
  input wire logic [7:0]  rsp_exc,
  input wire logic [1:0]  rsp_section,
  input wire logic [15:0] rsp_reg,
  input wire logic        rsp_zero_bits,
  // writes and field commands
  input wire logic        conc_wr,
  input wire logic [15:0] conc_addr,
  input wire logic        fcmd_valid,
  input wire logic        filt_drop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------
  sequence s_taken;
    rsp_valid && rsp_ready;
  endsequence
  sequence s_bad_end;
    rx_end && !rx_crc_ok && !rsp_valid && !fcmd_valid;
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  reply_done_a: assert property (s_taken |=> !rsp_valid)
    else $error("reply held after handshake");
  bad_crc_a: assert property (s_bad_end |=> !rsp_valid [*2])
    else $error("reply to a frame with bad crc");
  no_bcast_a: assert property (rsp_valid |-> rsp_unit != 8'h00)
    else $error("reply to broadcast address");
  base_legal_a: assert property (rsp_valid |-> cfg_base_addr inside {[8'h01:8'hf7]})
    else $error("reply with illegal base address");
  unit_sect_a: assert property (rsp_valid |-> rsp_unit - cfg_base_addr == {6'h00, rsp_section})
    else $error("section does not follow unit address");
  reply_stable_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_exc) && $stable(rsp_reg) && $stable(rsp_unit))
    else $error("reply changed while waiting");
  func_set_a: assert property (rsp_valid && rsp_exc == 8'h00 |->
    rsp_func inside {[8'h01:8'h06], 8'h08, 8'h0f, 8'h10, 8'h11, 8'h2b})
    else $error("unsupported code accepted");
  exc_set_a: assert property (rsp_valid |->
    rsp_exc inside {8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h0a})
    else $error("unknown exception code");
  zero_bits_a: assert property (rsp_valid && rsp_func == 8'h01 |->
    rsp_zero_bits == cfg_coil_zero)
    else $error("coil zero option not applied");
  conc_write_a: assert property (conc_wr |-> rsp_valid && rsp_exc == 8'h00 &&
    rsp_func inside {8'h05, 8'h06} && conc_addr <= 16'h00ff)
    else $error("bad concentrator write");
  cmd_after_a: assert property ($rose(fcmd_valid) |-> $past(rsp_valid && rsp_ready, 2))
    else $error("field command before reply taken");
  drop_quiet_a: assert property (filt_drop |-> !fcmd_valid && $past(rsp_valid && rsp_ready, 2))
    else $error("dropped command still offered");
endmodule
bind mbd_dispatch mbd_dispatch_monitor mbd_dispatch_monitor_inst (.clk, .rstn, .rx_end,
  .rx_crc_ok, .cfg_base_addr, .cfg_coil_zero, .rsp_valid, .rsp_ready, .rsp_unit, .rsp_func,
  .rsp_exc, .rsp_section, .rsp_reg, .rsp_zero_bits, .conc_wr, .conc_addr, .fcmd_valid,
  .filt_drop);
`default_nettype wire

// file: dv/mbd_sink.sv
`timescale 1ns/1ps
`default_nettype none
module mbd_sink (
  // clock and reset
  input wire logic  clk,
  input wire logic  rstn,
  // stall mode
  input wire logic  slow,
  // reply and command handshakes
  input wire logic  rsp_valid,
  output var logic  rsp_ready,
  input wire logic  fcmd_valid,
  output var logic  fcmd_ready
);
  // takes replies and field commands, stalling at random in slow mode
  // reply and command ready drawn independently
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp_ready <= 1'b0;
      fcmd_ready <= 1'b0;
    end else begin
      rsp_ready <= !slow || ($urandom % 3 == 0);
      fcmd_ready <= !slow || ($urandom % 3 == 0);
    end
  end
endmodule
`default_nettype wire

// file: dv/mbd_dispatch_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbd_dispatch_tb;
  logic         clk, rstn, rx_valid, rx_end, rx_crc_ok, cfg_coil_zero, cfg_tcp, gw_unavail, slow;
  logic [7:0]   rx_byte, cfg_base_addr, cfg_unit_count, ex;
  logic [15:0]  cfg_filter_ms, r;
  logic [239:0] unit_avail;
  wire          rsp_valid, rsp_ready, rsp_bit_mode, rsp_limit_src, rsp_zero_bits, rsp_pass;
  wire          conc_wr, fcmd_valid, fcmd_ready, filt_drop;
  wire [7:0]    rsp_unit, rsp_func, rsp_exc, fcmd_field_unit;
  wire [1:0]    rsp_section;
  wire [3:0]    rsp_bit;
  wire [15:0]   rsp_reg, rsp_qty, conc_addr, conc_data, fcmd_reg, fcmd_data;
  int           err_count, num_checks, drops, c, k;
  logic [58:0]  eq[$];
  logic [39:0]  fq[$];
  logic [58:0]  n;
  logic [39:0]  f;

  mbd_dispatch #(.TICK_CYCLES(4)) mbd_dispatch_inst (.clk, .rstn, .rx_valid, .rx_byte, .rx_end,
    .rx_crc_ok, .cfg_base_addr, .cfg_unit_count, .cfg_coil_zero, .cfg_filter_ms, .cfg_tcp,
    .gw_unavail, .unit_avail, .rsp_valid, .rsp_ready, .rsp_unit, .rsp_func, .rsp_exc,
    .rsp_section, .rsp_reg, .rsp_bit, .rsp_qty, .rsp_bit_mode, .rsp_limit_src, .rsp_zero_bits,
    .rsp_pass, .conc_wr, .conc_addr, .conc_data, .fcmd_valid, .fcmd_ready, .fcmd_field_unit,
    .fcmd_reg, .fcmd_data, .filt_drop);
  mbd_sink mbd_sink_inst (.clk, .rstn, .slow, .rsp_valid, .rsp_ready, .fcmd_valid, .fcmd_ready);

  // clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // compare one value
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // verdict
  task automatic end_of_test;
    if (err_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // compares one reply with the oldest noted request
  task automatic check_reply;
    logic [15:0] er;
    n = eq.pop_front();
    er = (n[39:32] < 8'h03) ? n[31:16] >> 4 : n[31:16];
    cmp(rsp_exc, n[57:50]);
    cmp(rsp_section, n[49:48]);
    cmp(rsp_unit, n[47:40]);
    cmp(rsp_func, n[39:32]);
    cmp(rsp_qty, n[15:0]);
    cmp(rsp_bit_mode, n[39:32] inside {8'h01, 8'h02});
    cmp(rsp_zero_bits, n[39:32] == 8'h01 && cfg_coil_zero);
    if (n[39:32] inside {8'h01, 8'h02})
      cmp(rsp_bit, n[19:16]);
    if (n[57:50] == 8'h00)
      cmp(rsp_pass, n[39:32] inside {8'h08, 8'h0f, 8'h10, 8'h11, 8'h2b});
    if (n[58]) begin
      cmp(rsp_reg, er);
      cmp(rsp_limit_src, n[39:32] == 8'h01 && er inside {[16'h0f00:16'h0f3b]});
    end
  endtask

  // compares one field command with the oldest noted command
  task automatic check_cmd;
    f = fq.pop_front();
    cmp(fcmd_field_unit, f[39:32]);
    cmp(fcmd_reg, f[31:16]);
    cmp(fcmd_data, f[15:0]);
  endtask

  // compares one concentrator write
  task automatic check_conc;
    cmp(conc_addr, 16'h0010);
    cmp(conc_data, 16'h0001);
  endtask

  // one frame, noting the expected reply, then waiting for idle
  task automatic send(input logic [7:0] u, input logic [7:0] fc, input logic [15:0] s,
                      input logic [15:0] q, input logic ok, input logic [7:0] e,
                      input logic chk);
    logic [63:0] fr;
    int          i;
    int          nsl;
    nsl = (cfg_unit_count + 59) / 60;
    if (nsl > 4)
      nsl = 4;
    fr = {u, fc, s, q, 16'ha55a};
    if (ok && u - cfg_base_addr < nsl && cfg_base_addr != 8'h00 && cfg_base_addr < 8'hf8)
      eq.push_back({chk, e, 2'(u - cfg_base_addr), u, fc, s, q});
    for (i = 0; i < 8; i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_byte = fr[63 - 8 * i -: 8];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_end = 1'b1;
    rx_crc_ok = ok;
    @(negedge clk);
    rx_end = 1'b0;
    for (i = 0; i < 300 && (eq.size() || fq.size()); i++)
      @(negedge clk);
    repeat (4) @(negedge clk);
  endtask

  // watches replies, writes and commands against the notes
  always @(posedge clk) begin
    if (rsp_valid && rsp_ready) begin
      if (eq.size() == 0)
        cmp(16'h0001, 16'h0000);
      else
        check_reply;
    end
    if (fcmd_valid && fcmd_ready) begin
      if (fq.size() == 0)
        cmp(16'h0001, 16'h0000);
      else
        check_cmd;
    end
    if (conc_wr)
      check_conc;
    if (filt_drop)
      drops++;
  end

  // watchdog
  initial begin
    #1000000;
    err_count++;
    end_of_test;
  end

  // main sequence
  initial begin
    {rstn, rx_valid, rx_end, rx_crc_ok, cfg_coil_zero, cfg_tcp, gw_unavail, slow} = 8'h00;
    rx_byte = 8'h00;
    cfg_base_addr = 8'h05;
    cfg_unit_count = 8'hc8;
    cfg_filter_ms = 16'h0040;
    unit_avail = {240{1'b1}};
    void'($urandom(32'h593d3446));
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    // function codes 0 to 44 on a concentrator location
    for (c = 0; c < 45; c++) begin
      case (c)
        1, 3, 4, 6, 8, 15, 16, 17, 43: ex = 8'h00;
        2: ex = 8'h02;
        5: ex = 8'h04;
        default: ex = 8'h01;
      endcase
      cfg_coil_zero = $urandom;
      send(8'h05, 8'(c), 16'h0010, 16'h0001, 1'b1, ex, c inside {1, 3, 4, 6});
    end
    // silent drops and slave count
    send(8'h00, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    send(8'h09, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    send(8'h05, 8'h03, 16'h0010, 16'h0001, 1'b0, 8'h00, 1'b1);
    cfg_unit_count = 8'h64;
    send(8'h07, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    send(8'h06, 8'h04, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    cfg_unit_count = 8'hc8;
    cfg_base_addr = 8'hf8;
    send(8'hf8, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    cfg_base_addr = 8'h05;
    gw_unavail = 1'b1;
    send(8'h05, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h00, 1'b1);
    cfg_tcp = 1'b1;
    send(8'h05, 8'h03, 16'h0010, 16'h0001, 1'b1, 8'h0a, 1'b0);
    {cfg_tcp, gw_unavail} = 2'b00;
    send(8'h05, 8'h10, 16'h0010, 16'd123, 1'b1, 8'h00, 1'b0);
    send(8'h05, 8'h10, 16'h0010, 16'd124, 1'b1, 8'h02, 1'b0);
    // random register reads on randomly chosen sections, partner stalling
    slow = 1'b1;
    for (c = 0; c < 8; c++) begin
      k = $urandom % 4;
      r = $urandom % 256;
      send(8'(5 + k), 8'(3 + c % 2), r, 16'h0001, 1'b1, 8'h00, 1'b1);
    end
    // coil read on the command region and a field-status bit read
    send(8'h06, 8'h01, 16'hf050, 16'h0001, 1'b1, 8'h00, 1'b1);
    send(8'h07, 8'h02, 16'h1000, 16'h0010, 1'b1, 8'h00, 1'b1);
    // field writes, duplicate filter and unavailable unit
    fq.push_back({8'd65, 16'h0f05, 16'hff00});
    send(8'h06, 8'h05, 16'h0f05, 16'hff00, 1'b1, 8'h00, 1'b1);
    send(8'h06, 8'h06, 16'h0f05, 16'hff00, 1'b1, 8'h00, 1'b1);
    unit_avail[65] = 1'b0;
    send(8'h06, 8'h06, 16'h0f05, 16'h0001, 1'b1, 8'h02, 1'b0);
    unit_avail[65] = 1'b1;
    fq.push_back({8'd182, 16'h0f02, 16'h0002});
    send(8'h08, 8'h06, 16'h0f02, 16'h0002, 1'b1, 8'h00, 1'b1);
    repeat (300) @(negedge clk);
    fq.push_back({8'd65, 16'h0f05, 16'hff00});
    send(8'h06, 8'h06, 16'h0f05, 16'hff00, 1'b1, 8'h00, 1'b1);
    cmp(16'(drops), 16'h0001);
    cmp(16'(eq.size() + fq.size()), 16'h0000);
    end_of_test;
  end
endmodule
`default_nettype wire
